// ### design/ltm_pkg.sv
// Shared constants for the load threshold monitor
package ltm_pkg;
   // Clock rate and seconds tick
   localparam int unsigned CLK_HZ = 25000000;
   localparam int unsigned TICK_PERIOD_S = 1;
   localparam int unsigned TICK_CYCLES = CLK_HZ * TICK_PERIOD_S;
   // Field widths
   localparam int PWR_W = 16;
   localparam int PCT_W = 8;
   localparam int SEC_W = 16;
   // Register offsets
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_RATED = 4'h1;
   localparam logic [3:0] REG_LOW_PCT = 4'h2;
   localparam logic [3:0] REG_LOW_DLY = 4'h3;
   localparam logic [3:0] REG_HIGH_PCT = 4'h4;
   localparam logic [3:0] REG_HIGH_DLY = 4'h5;
   localparam logic [3:0] REG_OBS_DLY = 4'h6;
   localparam logic [3:0] REG_STATUS = 4'h7;
   localparam logic [3:0] REG_INT_STAT = 4'h8;
   localparam logic [3:0] REG_INT_MASK = 4'h9;
   // Control field positions
   localparam int CTRL_MODE_BIT = 0;
   localparam int CTRL_OUT_ASSIGNED_BIT = 1;
   localparam int CTRL_EN_ASSIGNED_BIT = 2;
   // Interrupt status bits
   localparam int IRQ_ASSERT_BIT = 0;
   localparam int IRQ_DEASSERT_BIT = 1;
   localparam int IRQ_W = 2;
   // Reset values
   localparam logic [2:0] CTRL_RST = 3'h0;
   localparam logic [PWR_W-1:0] RATED_RST = 16'h0064;
   localparam logic [PCT_W-1:0] PCT_RST = 8'h00;
   localparam logic [SEC_W-1:0] DLY_RST = 16'h0000;
   localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;
   localparam logic PCT_SCALE = 1'b1;
   localparam logic [6:0] PCT_FULL = 7'h64;
   // Monitor states
   typedef enum logic [1:0] {LTM_OFF, LTM_OBSERVE, LTM_RUN} ltm_state_e;
endpackage

// ### design/ltm_sec_tick.sv
// Divider producing a one-cycle pulse once per second
`timescale 1ns/10ps
module ltm_sec_tick #(
   parameter int unsigned DIV = ltm_pkg::TICK_CYCLES
) (
   // Clock and reset
   input wire logic clock,
   input wire logic srst,
   // Seconds enable
   output logic tick
);
   logic [31:0] cnt_r;
   logic [31:0] cnt_nxt;
   wire logic wrap = (cnt_r == 32'(DIV - 1));
   assign cnt_nxt = wrap ? 32'h0 : cnt_r + 32'h1;
   always_ff @(posedge clock) begin
      if (srst) begin
         cnt_r <= 32'h0;
         tick <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         tick <= wrap;
      end
   end
endmodule

// ### design/ltm_qual_timer.sv
// Seconds qualification timer: done after a condition holds for a set time
`timescale 1ns/10ps
module ltm_qual_timer (
   // Clock and reset
   input wire logic clock,
   input wire logic srst,
   // Control
   input wire logic tick,
   input wire logic cond,
   input wire logic [ltm_pkg::SEC_W-1:0] delay_s,
   // Result
   output logic done
);
   logic [ltm_pkg::SEC_W-1:0] cnt_r;
   logic [ltm_pkg::SEC_W-1:0] cnt_nxt;
   wire logic reached = (cnt_r >= delay_s);
   always_comb begin
      cnt_nxt = cnt_r;
      if (!cond)
         cnt_nxt = '0;
      else if (tick && !reached)
         cnt_nxt = cnt_r + 1'b1;
   end
   // Done only while the condition still holds; a dropout restarts the count
   assign done = cond && reached;
   always_ff @(posedge clock) begin
      if (srst)
         cnt_r <= '0;
      else
         cnt_r <= cnt_nxt;
   end
endmodule

// ### design/ltm_top.sv
// Load threshold monitor: hysteresis on delivered power, drives one output
// How it works
// R01 - One mode bit: zero watches low power, one watches high power.
// R02 - Reset gives low-power mode and zero thresholds, so monitoring is off.
// R03 - Without an assigned output the monitor does nothing at all.
// R04 - With an enable input assigned, monitoring runs only while it is active.
// R05 - While disabled the output is held inactive whatever the power.
// R06 - After enable rises the output rests for the observation delay in seconds.
// R07 - Thresholds are percentages of the rated engine power.
// R08 - Each threshold has its own qualification delay in seconds.
// R09 - A zero threshold or lower not below upper disables the function.
// R10 - Both thresholds compare against total delivered active power.
// R11 - Low mode: power below lower for its delay sets the output.
// R12 - Low mode: power above upper for its delay clears the output.
// R13 - High mode: power below lower for its delay clears the output.
// R14 - High mode: power above upper for its delay sets the output.
// R15 - Software should keep the high-mode lower threshold low to avoid swinging.
// R16 - A condition ending early restarts its delay, output unchanged.
// R17 - Without an enable input the function is always on, no observation delay.
// R18 - Between thresholds the output keeps its previous state.
`timescale 1ns/10ps
module ltm_top (
   // Clock and reset
   input wire logic clock,
   input wire logic srst,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Power measurement, same clock domain
   input wire logic [ltm_pkg::PWR_W-1:0] total_active_power,
   // Enable pin from outside
   input wire logic load_threshold_enable_input,
   // Output pin and interrupt
   output logic load_threshold_output_function,
   output logic irq
);
   // Configuration registers
   logic [2:0] ctrl_r;
   logic [ltm_pkg::PWR_W-1:0] rated_r;
   logic [ltm_pkg::PCT_W-1:0] low_pct_r;
   logic [ltm_pkg::PCT_W-1:0] high_pct_r;
   logic [ltm_pkg::SEC_W-1:0] low_dly_r;
   logic [ltm_pkg::SEC_W-1:0] high_dly_r;
   logic [ltm_pkg::SEC_W-1:0] obs_dly_r;
   logic [ltm_pkg::IRQ_W-1:0] int_stat_r;
   logic [ltm_pkg::IRQ_W-1:0] int_mask_r;
   logic [ltm_pkg::IRQ_W-1:0] int_stat_nxt;
   // Monitor state
   ltm_pkg::ltm_state_e state_r;
   ltm_pkg::ltm_state_e state_nxt;
   logic out_r;
   logic out_nxt;
   logic [ltm_pkg::SEC_W-1:0] obs_cnt_r;
   logic [ltm_pkg::SEC_W-1:0] obs_cnt_nxt;
   logic en_meta_r;
   logic en_sync_r;
   logic tick;
   logic low_done;
   logic high_done;

   // Threshold in watts-units: rated * pct / 100, rounded down
   function automatic logic [ltm_pkg::PWR_W-1:0] pct_of(
      input logic [ltm_pkg::PWR_W-1:0] rated,
      input logic [ltm_pkg::PCT_W-1:0] pct
   );
      logic [ltm_pkg::PWR_W+ltm_pkg::PCT_W-1:0] prod;
      logic [ltm_pkg::PWR_W+ltm_pkg::PCT_W-1:0] quo;
      prod = rated * pct;
      quo = prod / {{(ltm_pkg::PWR_W+ltm_pkg::PCT_W-7){1'b0}}, ltm_pkg::PCT_FULL};
      // Clamp above-range results rather than wrap
      pct_of = (quo[ltm_pkg::PWR_W+ltm_pkg::PCT_W-1:ltm_pkg::PWR_W] != '0)
         ? '1 : quo[ltm_pkg::PWR_W-1:0];
   endfunction

   // Two-flop synchroniser for the enable pin
   always_ff @(posedge clock) begin
      if (srst) begin
         en_meta_r <= 1'b0;
         en_sync_r <= 1'b0;
      end else begin
         en_meta_r <= load_threshold_enable_input;
         en_sync_r <= en_meta_r;
      end
   end

   // Control field decode
   // R01 mode select
   wire logic mode_high = ctrl_r[ltm_pkg::CTRL_MODE_BIT];
   wire logic out_assigned = ctrl_r[ltm_pkg::CTRL_OUT_ASSIGNED_BIT];
   wire logic en_assigned = ctrl_r[ltm_pkg::CTRL_EN_ASSIGNED_BIT];

   // R09 threshold sanity
   wire logic thr_valid = (low_pct_r != '0) && (high_pct_r != '0) && (low_pct_r < high_pct_r);
   // R04 R17 enable source
   wire logic en_active = en_assigned ? en_sync_r : 1'b1;
   // R03 overall enable
   wire logic func_on = out_assigned && thr_valid && en_active;

   // R07 R10 comparisons on total delivered power
   wire logic [ltm_pkg::PWR_W-1:0] low_thr = pct_of(rated_r, low_pct_r);
   wire logic [ltm_pkg::PWR_W-1:0] high_thr = pct_of(rated_r, high_pct_r);
   wire logic below_low = (total_active_power < low_thr);
   wire logic above_high = (total_active_power > high_thr);
   wire logic running = (state_r == ltm_pkg::LTM_RUN);

   ltm_sec_tick u_tick (
      .clock(clock),
      .srst(srst),
      .tick(tick)
   );

   // R08 R16 separate qualification timers
   ltm_qual_timer u_low_timer (
      .clock(clock),
      .srst(srst),
      .tick(tick),
      .cond(running && below_low),
      .delay_s(low_dly_r),
      .done(low_done)
   );

   ltm_qual_timer u_high_timer (
      .clock(clock),
      .srst(srst),
      .tick(tick),
      .cond(running && above_high),
      .delay_s(high_dly_r),
      .done(high_done)
   );

   // Enable sequencing and output decision
   always_comb begin
      state_nxt = state_r;
      obs_cnt_nxt = obs_cnt_r;
      out_nxt = out_r;
      case (state_r)
         ltm_pkg::LTM_OFF: begin
            out_nxt = 1'b0;
            obs_cnt_nxt = '0;
            if (func_on) begin
               // R06 R17 observation only with an enable input
               state_nxt = en_assigned ? ltm_pkg::LTM_OBSERVE : ltm_pkg::LTM_RUN;
            end
         end
         ltm_pkg::LTM_OBSERVE: begin
            out_nxt = 1'b0;
            // R06 rest through observation
            if (obs_cnt_r >= obs_dly_r)
               state_nxt = ltm_pkg::LTM_RUN;
            else if (tick)
               obs_cnt_nxt = obs_cnt_r + 1'b1;
         end
         ltm_pkg::LTM_RUN: begin
            // R11 R14 assert on qualified crossing
            if (mode_high ? high_done : low_done)
               out_nxt = 1'b1;
            // R12 R13 deassert on opposite crossing
            else if (mode_high ? low_done : high_done)
               out_nxt = 1'b0;
            // R18 otherwise hold
         end
         default: begin
            state_nxt = ltm_pkg::LTM_OFF;
            out_nxt = 1'b0;
         end
      endcase
      // R05 disabled forces rest
      if (!func_on) begin
         state_nxt = ltm_pkg::LTM_OFF;
         out_nxt = 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (srst)
         state_r <= ltm_pkg::LTM_OFF;
      else
         state_r <= state_nxt;
   end

   always_ff @(posedge clock) begin
      if (srst)
         out_r <= 1'b0;
      else
         out_r <= out_nxt;
   end

   always_ff @(posedge clock) begin
      if (srst)
         obs_cnt_r <= '0;
      else
         obs_cnt_r <= obs_cnt_nxt;
   end

   assign load_threshold_output_function = out_r;

   // Register write decode
   wire logic wr_ctrl = reg_wr && (reg_addr == ltm_pkg::REG_CTRL);
   wire logic wr_rated = reg_wr && (reg_addr == ltm_pkg::REG_RATED);
   wire logic wr_low_pct = reg_wr && (reg_addr == ltm_pkg::REG_LOW_PCT);
   wire logic wr_low_dly = reg_wr && (reg_addr == ltm_pkg::REG_LOW_DLY);
   wire logic wr_high_pct = reg_wr && (reg_addr == ltm_pkg::REG_HIGH_PCT);
   wire logic wr_high_dly = reg_wr && (reg_addr == ltm_pkg::REG_HIGH_DLY);
   wire logic wr_obs = reg_wr && (reg_addr == ltm_pkg::REG_OBS_DLY);
   wire logic wr_istat = reg_wr && (reg_addr == ltm_pkg::REG_INT_STAT);
   wire logic wr_imask = reg_wr && (reg_addr == ltm_pkg::REG_INT_MASK);

   // Output edge events; set beats a same-cycle write-one clear
   wire logic [ltm_pkg::IRQ_W-1:0] ev = {out_r & ~out_nxt, ~out_r & out_nxt};
   wire logic [ltm_pkg::IRQ_W-1:0] w1c = wr_istat ? reg_wdata[ltm_pkg::IRQ_W-1:0] : '0;
   assign int_stat_nxt = (int_stat_r & ~w1c) | ev;

   // R02 reset defaults
   always_ff @(posedge clock) begin
      if (srst)
         ctrl_r <= ltm_pkg::CTRL_RST;
      else if (wr_ctrl)
         ctrl_r <= reg_wdata[2:0];
   end

   always_ff @(posedge clock) begin
      if (srst)
         rated_r <= ltm_pkg::RATED_RST;
      else if (wr_rated)
         rated_r <= reg_wdata[ltm_pkg::PWR_W-1:0];
   end

   always_ff @(posedge clock) begin
      if (srst)
         low_pct_r <= ltm_pkg::PCT_RST;
      else if (wr_low_pct)
         low_pct_r <= reg_wdata[ltm_pkg::PCT_W-1:0];
   end

   always_ff @(posedge clock) begin
      if (srst)
         high_pct_r <= ltm_pkg::PCT_RST;
      else if (wr_high_pct)
         high_pct_r <= reg_wdata[ltm_pkg::PCT_W-1:0];
   end

   always_ff @(posedge clock) begin
      if (srst)
         low_dly_r <= ltm_pkg::DLY_RST;
      else if (wr_low_dly)
         low_dly_r <= reg_wdata[ltm_pkg::SEC_W-1:0];
   end

   always_ff @(posedge clock) begin
      if (srst)
         high_dly_r <= ltm_pkg::DLY_RST;
      else if (wr_high_dly)
         high_dly_r <= reg_wdata[ltm_pkg::SEC_W-1:0];
   end

   always_ff @(posedge clock) begin
      if (srst)
         obs_dly_r <= ltm_pkg::DLY_RST;
      else if (wr_obs)
         obs_dly_r <= reg_wdata[ltm_pkg::SEC_W-1:0];
   end

   always_ff @(posedge clock) begin
      if (srst)
         int_mask_r <= ltm_pkg::IRQ_RST;
      else if (wr_imask)
         int_mask_r <= reg_wdata[ltm_pkg::IRQ_W-1:0];
   end

   always_ff @(posedge clock) begin
      if (srst)
         int_stat_r <= ltm_pkg::IRQ_RST;
      else
         int_stat_r <= int_stat_nxt;
   end

   assign irq = |(int_stat_r & int_mask_r);

   // Read mux; unmapped addresses read zero
   logic [31:0] rd_mux;
   always_comb begin
      case (reg_addr)
         ltm_pkg::REG_CTRL: rd_mux = {29'h0, ctrl_r};
         ltm_pkg::REG_RATED: rd_mux = {16'h0, rated_r};
         ltm_pkg::REG_LOW_PCT: rd_mux = {24'h0, low_pct_r};
         ltm_pkg::REG_LOW_DLY: rd_mux = {16'h0, low_dly_r};
         ltm_pkg::REG_HIGH_PCT: rd_mux = {24'h0, high_pct_r};
         ltm_pkg::REG_HIGH_DLY: rd_mux = {16'h0, high_dly_r};
         ltm_pkg::REG_OBS_DLY: rd_mux = {16'h0, obs_dly_r};
         ltm_pkg::REG_STATUS: rd_mux = {26'h0, state_r, en_sync_r, func_on, out_r, thr_valid};
         ltm_pkg::REG_INT_STAT: rd_mux = {30'h0, int_stat_r};
         ltm_pkg::REG_INT_MASK: rd_mux = {30'h0, int_mask_r};
         default: rd_mux = 32'h0;
      endcase
   end

   // Read data valid only the cycle after the strobe
   always_ff @(posedge clock) begin
      if (srst)
         reg_rdata <= 32'h0;
      else
         reg_rdata <= reg_rd ? rd_mux : 32'h0;
   end
endmodule

// ### tb/ltm_checker_assertions.sv
// Port-level checks on the load threshold monitor
`timescale 1ns/10ps
module ltm_checker (
   // Clock and reset
   input wire logic clock,
   input wire logic srst,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   // Monitor pins
   input wire logic [ltm_pkg::PWR_W-1:0] total_active_power,
   input wire logic load_threshold_enable_input,
   input wire logic load_threshold_output_function,
   input wire logic irq
);
   default clocking @(posedge clock); endclocking
   default disable iff (srst);
   logic [15:0] reg_r [16];
   logic [1:0] en_s_r;
   wire out_w = load_threshold_output_function;
   wire [2:0] ctl = reg_r[0][2:0];
   wire [23:0] lo_thr = (24'(reg_r[1]) * 24'(reg_r[2][7:0])) / 24'h64;
   wire [23:0] hi_thr = (24'(reg_r[1]) * 24'(reg_r[4][7:0])) / 24'h64;
   wire below = 24'(total_active_power) < lo_thr;
   wire above = 24'(total_active_power) > hi_thr;
   wire set_c = ctl[0] ? above : below;
   wire clr_c = ctl[0] ? below : above;
   wire thr_ok = reg_r[2][7:0] != 8'h00 && reg_r[4][7:0] != 8'h00
      && reg_r[2][7:0] < reg_r[4][7:0];
   wire func_ok = ctl[1] && thr_ok && (!ctl[2] || en_s_r[1]);
   // Shadow of the written registers, mirrors the write timing
   always_ff @(posedge clock) begin
      en_s_r <= {en_s_r[0], load_threshold_enable_input};
      for (int i = 0; i < 16; i++) begin
         if (srst)
            reg_r[i] <= (i == 1) ? ltm_pkg::RATED_RST : 16'h0000;
         else if (reg_wr && reg_addr == 4'(i))
            reg_r[i] <= reg_wdata[15:0];
      end
   end
   a_unassigned_quiet: assert property ((!ctl[1])[*2] |-> !out_w)
      else $error("Output active while unassigned");
   a_enable_gates_out: assert property ((ctl[2] && !load_threshold_enable_input)[*4] |-> !out_w)
      else $error("Output active with enable low");
   a_bad_thr_quiet: assert property ((!thr_ok)[*2] |-> !out_w)
      else $error("Output active with unusable thresholds");
   a_band_hold: assert property ((func_ok && !set_c && !clr_c)[*3] |=> $stable(out_w))
      else $error("Output moved inside the band");
   a_rise_cause: assert property ($rose(out_w) |-> $past(set_c) || $past(set_c, 2))
      else $error("Output rose without its crossing");
   a_fall_cause: assert property ($fell(out_w) |-> $past(clr_c) || $past(clr_c, 2)
      || !$past(func_ok) || !$past(func_ok, 2))
      else $error("Output fell without cause");
   a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
      else $error("Read data outside its cycle");
   a_irq_masked: assert property (irq |-> reg_r[9][1:0] != 2'h0)
      else $error("Interrupt with all sources masked");
endmodule
bind ltm_top ltm_checker chk_u (.clock(clock), .srst(srst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .total_active_power(total_active_power),
   .load_threshold_enable_input(load_threshold_enable_input),
   .load_threshold_output_function(load_threshold_output_function), .irq(irq));

// ### tb/ltm_power_model.sv
// Power measurement path and enable line feeding the monitor
`timescale 1ns/10ps
module ltm_power_model (
   // Clock
   input wire logic clock,
   // Lines into the monitor
   output logic [ltm_pkg::PWR_W-1:0] total_active_power,
   output logic load_threshold_enable_input
);
   initial begin
      total_active_power = 16'h0000;
      load_threshold_enable_input = 1'b0;
   end
   task automatic set_power(input logic [15:0] p);
      @(posedge clock);
      total_active_power <= p;
   endtask
   task automatic set_en(input logic e);
      @(posedge clock);
      load_threshold_enable_input <= e;
   endtask
endmodule

// ### tb/load_threshold_monitor_tb_top.sv
// Self-checking bench for the load threshold monitor
`timescale 1ns/10ps
module load_threshold_monitor_tb_top;
   logic clock;
   logic srst;
   logic [3:0] reg_addr;
   logic [31:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [31:0] reg_rdata;
   logic [ltm_pkg::PWR_W-1:0] pwr;
   logic en;
   logic out;
   logic irq;
   int err_total;
   int checks;
   ltm_top dut_u (.clock(clock), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .total_active_power(pwr),
      .load_threshold_enable_input(en), .load_threshold_output_function(out), .irq(irq));
   ltm_power_model pm_u (.clock(clock), .total_active_power(pwr),
      .load_threshold_enable_input(en));
   // Short second so qualification delays fit the run
   defparam dut_u.u_tick.DIV = 10;
   task automatic chk(input string w, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", w, exp, seen);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   task automatic rdchk(input string w, input logic [3:0] a, input logic [31:0] e);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 chk(w, reg_rdata, e);
   endtask
   task automatic wait_out(input logic e, input int n);
      // Sample only once the edge's updates have settled
      #1;
      for (int i = 0; i < n && out !== e; i++) begin
         @(posedge clock);
         #1;
      end
      chk("output", {31'h0, out}, {31'h0, e});
   endtask
   task automatic stay(input logic e, input int n);
      repeat (n) @(posedge clock);
      #1 chk("output", {31'h0, out}, {31'h0, e});
   endtask
   task automatic cfg(input logic [2:0] c, input logic [15:0] ld, input logic [15:0] hd);
      wr(ltm_pkg::REG_LOW_PCT, 32'h14);
      wr(ltm_pkg::REG_LOW_DLY, {16'h0, ld});
      wr(ltm_pkg::REG_HIGH_PCT, 32'h3C);
      wr(ltm_pkg::REG_HIGH_DLY, {16'h0, hd});
      wr(ltm_pkg::REG_CTRL, {29'h0, c});
   endtask
   task automatic t_reset;
      rdchk("ctrl", ltm_pkg::REG_CTRL, 32'h0);
      rdchk("rated", ltm_pkg::REG_RATED, 32'h64);
      rdchk("low pct", ltm_pkg::REG_LOW_PCT, 32'h0);
      rdchk("unmapped", 4'hF, 32'h0);
      chk("output", {31'h0, out}, 32'h0);
      $display("test reset done");
   endtask
   task automatic t_low;
      cfg(3'h0, 16'h2, 16'h1);
      pm_u.set_power(16'h13);
      stay(1'b0, 30);
      wr(ltm_pkg::REG_CTRL, 32'h2);
      repeat (5) @(posedge clock);
      pm_u.set_power(16'h28);
      stay(1'b0, 40);
      pm_u.set_power(16'h14);
      stay(1'b0, 40);
      pm_u.set_power(16'h13);
      wait_out(1'b1, 40);
      pm_u.set_power(16'h3C);
      stay(1'b1, 40);
      pm_u.set_power(16'h3D);
      wait_out(1'b0, 40);
      rdchk("int stat", ltm_pkg::REG_INT_STAT, 32'h3);
      wr(ltm_pkg::REG_INT_MASK, 32'h1);
      #1 chk("irq", {31'h0, irq}, 32'h1);
      wr(ltm_pkg::REG_INT_STAT, 32'h1);
      #1 chk("irq", {31'h0, irq}, 32'h0);
      wr(ltm_pkg::REG_INT_STAT, 32'h2);
      rdchk("int stat", ltm_pkg::REG_INT_STAT, 32'h0);
      $display("test low mode done");
   endtask
   task automatic t_high;
      // lower threshold kept well under the upper
      cfg(3'h3, 16'h0, 16'h0);
      wait_out(1'b1, 20);
      pm_u.set_power(16'h13);
      wait_out(1'b0, 20);
      $display("test high mode done");
   endtask
   task automatic t_bad;
      cfg(3'h2, 16'h0, 16'h0);
      pm_u.set_power(16'h46);
      wait_out(1'b0, 20);
      // Power 30 lies in the band at rated 100, below lower only at rated 200
      wr(ltm_pkg::REG_RATED, 32'hC8);
      pm_u.set_power(16'h1E);
      wait_out(1'b1, 20);
      wr(ltm_pkg::REG_HIGH_PCT, 32'h0);
      wait_out(1'b0, 5);
      wr(ltm_pkg::REG_LOW_PCT, 32'h3C);
      wr(ltm_pkg::REG_HIGH_PCT, 32'h3C);
      stay(1'b0, 20);
      wr(ltm_pkg::REG_LOW_PCT, 32'h14);
      wait_out(1'b1, 20);
      $display("test thresholds done");
   endtask
   task automatic t_enable;
      wr(ltm_pkg::REG_OBS_DLY, 32'h3);
      wr(ltm_pkg::REG_CTRL, 32'h6);
      stay(1'b0, 20);
      pm_u.set_en(1'b1);
      stay(1'b0, 15);
      // Observe state, enable synced, function on, output at rest, thresholds valid
      rdchk("status", ltm_pkg::REG_STATUS, 32'h1D);
      wait_out(1'b1, 60);
      pm_u.set_en(1'b0);
      wait_out(1'b0, 6);
      $display("test enable done");
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   // Whole run is a few hundred cycles; the timeout is 20000 cycles
   initial begin
      #800000;
      err_total++;
      conclude();
   end
   initial begin
      srst = 1'b1;
      reg_addr = 4'h0;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      err_total = 0;
      checks = 0;
      repeat (2) @(posedge clock);
      srst <= 1'b0;
      t_reset();
      t_low();
      t_high();
      t_bad();
      t_enable();
      conclude();
   end
endmodule
